//--- hdl/converter_control_word.sv
// converter control word: serial byte access on the link clock, fields and result shaping on clk_i
// ============================================================================
// Overview of operation
// R1: each written byte takes effect on the falling shift clock of its last bit; here the fields change on the third clk_i rising edge after it
// R2: four bytes: byte 3 flags, byte 2 mode/gain/channel, bytes 1-0 turbo/decimation
// R3: reset value zero except reference enable one and decimation ratio 23
// R4: bias generator enable follows bit 7 of byte 3
// R5: internal reference enable follows its bit, one after reset
// R6: format bit 0 gives two's complement results, 1 gives offset binary
// R7: offset binary is made by inverting the msb, only in the result register
// R8: unipolar bit clamps result register values to zero or positive only
// R9: after clearing unipolar, the next completed conversion is unclamped
// R10: byte order 0 reads ascending addresses, 1 reads descending addresses
// R11: writes always step to ascending addresses
// R12: bit order 0 shifts reads msb first, 1 lsb first; writes unaffected
// R13: pin select 0 outputs on the data pin, 1 on the dedicated output
// R14: dedicated output stays tri-stated while pin select is 0
// R15: host should set pin select early to stop unwanted data pin driving
// R16: ready position reads the active-low ready level and is not writable
// R17: writing 1 to the resync position resets the modulator count
// R18: resync and ready share one bit position, write and read differ
// R19: resync is a one-shot pulse, never stored or read back
// R20: normal, background and sleep modes persist; others revert to normal
// R21: after a channel change the first three ready indications are invalid
// R22: host keeps gain times turbo rate at most sixteen
// R23: host keeps decimation ratio between 19 and 8000
`timescale 1ns/1ps
`default_nettype none

module converter_control_word
    import ctrl_word_pkg::*;
#(
    parameter int RES_W = RESULT_W
) (
    // system clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    // serial link, data phase framed by the instruction decoder
    input  wire logic                 sclk_i,
    input  wire logic                 xfer_active_i,
    input  wire logic                 xfer_read_i,
    input  wire logic [1:0]           xfer_start_idx_i,
    input  wire logic                 sdio_i,
    output logic                      sdio_o,
    output logic                      sdio_oe_o,
    output logic                      dedicated_serial_out_o,
    output logic                      dedicated_serial_out_oe_o,
    // converter status and results on clk_i
    input  wire logic                 result_ready_n_i,
    input  wire logic                 mode_done_i,
    input  wire logic                 raw_result_valid_i,
    input  wire logic [RES_W-1:0]     raw_result_i,
    // converter controls
    output logic                      bias_enable_o,
    output logic                      internal_ref_enable_o,
    output logic [2:0]                op_mode_field_o,
    output logic [2:0]                gain_field_o,
    output logic [1:0]                channel_select_field_o,
    output logic [2:0]                turbo_rate_field_o,
    output logic [DECIM_W-1:0]        decimation_field_o,
    output logic                      conversion_resync_o,
    // shaped result
    output logic [RES_W-1:0]          result_register_o,
    output logic                      result_trusted_o
);
    import ctrl_word_pkg::*;

    // ========================================================================
    // helpers

    // byte at serial index idx; index 0 is byte 3
    function automatic logic [7:0] byte_at(input logic [31:0] w, input logic [1:0] idx);
        logic [4:0] lsb;
        lsb = 5'((2'h3 - idx) * 8);
        return w[lsb +: 8];
    endfunction

    // temporary modes revert to normal when their actions finish
    function automatic logic mode_is_temporary(input logic [2:0] m);
        return !(m == MODE_NORMAL || m == MODE_BACKGROUND || m == MODE_SLEEP);
    endfunction

    // ========================================================================
    // link domain: reset and register mirror synchronisers
    logic        lrst1_q;
    logic        lrst2_q;
    logic [31:0] mir1_q;
    logic [31:0] mir2_q;
    logic [31:0] view_q;                        // clk_i copy of what a read returns

    // limitation: a read just after a write may still show the old bits
    // each mirror bit is a level that changes only long after the write that set it
    always_ff @(negedge sclk_i) begin
        lrst1_q <= resetn_i;
        lrst2_q <= lrst1_q;
        mir1_q  <= view_q;
        mir2_q  <= mir1_q;
    end

    // ========================================================================
    // link domain: byte shifter, runs on the falling shift clock edge
    logic [2:0]  bit_q,    bit_d;
    logic [1:0]  idx_q,    idx_d;
    logic [6:0]  shift_q,  shift_d;
    logic [7:0]  wr_data_q, wr_data_d;
    logic [1:0]  wr_idx_q, wr_idx_d;
    logic        wr_tgl_q, wr_tgl_d;
    logic        sdio_q,   sdio_d;
    logic        sdio_oe_q, sdio_oe_d;
    logic        dedicated_serial_out_q,  dedicated_serial_out_d;
    logic        dedicated_serial_out_oe_q, dedicated_serial_out_oe_d;

    // next values of the shifter
    always_comb begin
        logic [7:0] rd_byte;
        logic [2:0] pos;
        logic       out_bit;
        rd_byte    = byte_at(mir2_q, idx_q);
        pos        = mir2_q[BIT_ORDER_BIT] ? bit_q : (LAST_BIT - bit_q);       // R12
        out_bit    = rd_byte[pos];
        bit_d      = bit_q;
        idx_d      = idx_q;
        shift_d    = shift_q;
        wr_data_d  = wr_data_q;
        wr_idx_d   = wr_idx_q;
        wr_tgl_d   = wr_tgl_q;
        sdio_d     = 1'b0;
        sdio_oe_d  = 1'b0;
        dedicated_serial_out_d    = 1'b0;
        dedicated_serial_out_oe_d = 1'b0;

        if (!xfer_active_i) begin
            // frame over: next frame starts on the decoder's start index
            bit_d = 3'h0;
            idx_d = xfer_start_idx_i;
        end else begin
            bit_d = bit_q + 3'h1;
            if (xfer_read_i) begin
                // read data goes out on one pin only
                if (mir2_q[PIN_SEL_BIT]) begin                                // R13
                    dedicated_serial_out_d    = out_bit;
                    dedicated_serial_out_oe_d = 1'b1;
                end else begin
                    sdio_d    = out_bit;                                      // R13
                    sdio_oe_d = 1'b1;
                end
                if (bit_q == LAST_BIT) begin
                    idx_d = mir2_q[BYTE_ORDER_BIT] ? idx_q - 2'h1 : idx_q + 2'h1;  // R10
                end
            end else begin
                // writes are always msb first whatever the bit order setting
                shift_d = {shift_q[5:0], sdio_i};                             // R12
                if (bit_q == LAST_BIT) begin
                    wr_data_d = {shift_q, sdio_i};
                    wr_idx_d  = idx_q;
                    wr_tgl_d  = ~wr_tgl_q;                                    // R1
                    idx_d     = idx_q + 2'h1;                                 // R11
                end
            end
        end
        // the dedicated output floats whenever pin select is clear
        if (!mir2_q[PIN_SEL_BIT]) begin
            dedicated_serial_out_oe_d = 1'b0;                                                // R14
        end
    end

    // shifter registers
    always_ff @(negedge sclk_i) begin
        if (!lrst2_q) begin
            bit_q      <= 3'h0;
            idx_q      <= 2'h0;
            shift_q    <= 7'h00;
            wr_data_q  <= 8'h00;
            wr_idx_q   <= 2'h0;
            wr_tgl_q   <= 1'b0;
            sdio_q     <= 1'b0;
            sdio_oe_q  <= 1'b0;
            dedicated_serial_out_q    <= 1'b0;
            dedicated_serial_out_oe_q <= 1'b0;
        end else begin
            bit_q      <= bit_d;
            idx_q      <= idx_d;
            shift_q    <= shift_d;
            wr_data_q  <= wr_data_d;
            wr_idx_q   <= wr_idx_d;
            wr_tgl_q   <= wr_tgl_d;
            sdio_q     <= sdio_d;
            sdio_oe_q  <= sdio_oe_d;
            dedicated_serial_out_q    <= dedicated_serial_out_d;
            dedicated_serial_out_oe_q <= dedicated_serial_out_oe_d;
        end
    end

    assign sdio_o                    = sdio_q;
    assign sdio_oe_o                 = sdio_oe_q;
    assign dedicated_serial_out_o    = dedicated_serial_out_q;
    assign dedicated_serial_out_oe_o = dedicated_serial_out_oe_q;

    // ========================================================================
    // clk_i domain: toggle synchroniser for completed write bytes
    logic        tg1_q;
    logic        tg2_q;
    logic        tg3_q;
    logic        wr_evt;

    // byte data and index are held by the link side for a whole byte time
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tg1_q <= 1'b0;
            tg2_q <= 1'b0;
            tg3_q <= 1'b0;
        end else begin
            tg1_q <= wr_tgl_q;
            tg2_q <= tg1_q;
            tg3_q <= tg2_q;
        end
    end

    // one event per byte, whichever way the toggle moved
    assign wr_evt = tg2_q ^ tg3_q;

    // ========================================================================
    // clk_i domain: the control word itself
    logic [31:0] word_q,   word_d;
    logic        resync_q, resync_d;

    // field updates; a host write wins over the automatic return to normal
    always_comb begin
        word_d   = word_q;
        resync_d = 1'b0;
        if (mode_done_i && mode_is_temporary(word_q[MODE_LSB +: 3])) begin
            word_d[MODE_LSB +: 3] = MODE_NORMAL;                              // R20
        end
        if (wr_evt) begin
            case (wr_idx_q)
                IDX_BYTE3: begin
                    // ready position is read only; a one there is a resync pulse
                    word_d[31:25] = wr_data_q[7:1];                           // R2 R4 R5
                    resync_d      = wr_data_q[RESYNC_BIT_IN_BYTE];            // R17 R18 R19
                end
                IDX_BYTE2: word_d[23:16] = wr_data_q;                         // R2
                IDX_BYTE1: word_d[15:8]  = wr_data_q;                         // R2
                IDX_BYTE0: word_d[7:0]   = wr_data_q;                         // R2
                default:   word_d        = word_q;
            endcase
        end

        // the ready level lives only in the read view
        word_d[READY_BIT] = 1'b0;                                             // R16
    end

    // word register, reset to its documented defaults
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            word_q   <= WORD_RESET;                                           // R3
            resync_q <= 1'b0;
        end else begin
            word_q   <= word_d;                                               // R1
            resync_q <= resync_d;
        end
    end

    // the read view carries the live ready level in place of the resync strobe
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            view_q <= WORD_RESET | (32'h1 << READY_BIT);
        end else begin
            view_q <= {word_d[31:25], result_ready_n_i, word_d[23:0]};        // R16 R18
        end
    end

    assign bias_enable_o          = word_q[BIAS_BIT];                         // R4
    assign internal_ref_enable_o  = word_q[REF_BIT];                          // R5
    assign op_mode_field_o        = word_q[MODE_LSB +: 3];
    assign gain_field_o           = word_q[GAIN_LSB +: 3];
    assign channel_select_field_o = word_q[CHAN_LSB +: 2];
    assign turbo_rate_field_o     = word_q[TURBO_LSB +: 3];
    assign decimation_field_o     = word_q[DECIM_LSB +: DECIM_W];
    assign conversion_resync_o    = resync_q;                                 // R19

    // ========================================================================
    // clk_i domain: result shaping and channel settling
    logic [RES_W-1:0] result_q,  result_d;
    logic [1:0]       skip_q,    skip_d;
    logic             rdy_q;
    logic             trusted_q, trusted_d;

    // clamp first, then format; internal data is never touched
    always_comb begin
        logic [RES_W-1:0] v;
        v         = raw_result_i;
        result_d  = result_q;
        skip_d    = skip_q;
        trusted_d = trusted_q;

        if (raw_result_valid_i) begin
            // bipolar results pass on the very next conversion after clearing
            if (word_q[UNIPOLAR_BIT] && v[RES_W-1]) begin                    // R8 R9
                v = '0;
            end
            if (word_q[FORMAT_BIT]) begin
                v[RES_W-1] = ~v[RES_W-1];                                    // R6 R7
            end
            result_d = v;
        end
        // each falling ready edge consumes one of the settling results
        if (rdy_q && !result_ready_n_i) begin
            trusted_d = (skip_q == 2'h0);                                     // R21
            if (skip_q != 2'h0) begin
                skip_d = skip_q - 2'h1;
            end
        end

        // a changed channel restarts the settling count
        if (wr_evt && wr_idx_q == IDX_BYTE2 && wr_data_q[1:0] != word_q[CHAN_LSB +: 2]) begin
            skip_d    = CHAN_SKIP_COUNT;                                      // R21
            trusted_d = 1'b0;
        end
    end

    // result and settling registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            result_q  <= '0;
            skip_q    <= 2'h0;
            rdy_q     <= 1'b1;
            trusted_q <= 1'b0;
        end else begin
            result_q  <= result_d;
            skip_q    <= skip_d;
            rdy_q     <= result_ready_n_i;
            trusted_q <= trusted_d;
        end
    end

    assign result_register_o = result_q;
    assign result_trusted_o  = trusted_q;

endmodule

`default_nettype wire

//--- hdl/ctrl_word_pkg.sv
// constants shared by the converter control word logic
package ctrl_word_pkg;

    // ========================================================================
    // serial addressing of the control word (byte 3 sits at the lowest address)
    localparam int          WORD_BYTES        = 4;
    localparam logic [3:0]  CMR_BASE_ADDR     = 4'h4;
    localparam logic [1:0]  IDX_BYTE3         = 2'h0;
    localparam logic [1:0]  IDX_BYTE2         = 2'h1;
    localparam logic [1:0]  IDX_BYTE1         = 2'h2;
    localparam logic [1:0]  IDX_BYTE0         = 2'h3;
    localparam logic [2:0]  LAST_BIT          = 3'h7;

    // ========================================================================
    // field positions inside the 32-bit word
    localparam int          BIAS_BIT          = 31;
    localparam int          REF_BIT           = 30;
    localparam int          FORMAT_BIT        = 29;
    localparam int          UNIPOLAR_BIT      = 28;
    localparam int          BYTE_ORDER_BIT    = 27;
    localparam int          BIT_ORDER_BIT     = 26;
    localparam int          PIN_SEL_BIT       = 25;
    localparam int          READY_BIT         = 24;
    localparam int          MODE_LSB          = 21;
    localparam int          GAIN_LSB          = 18;
    localparam int          CHAN_LSB          = 16;
    localparam int          TURBO_LSB         = 13;
    localparam int          DECIM_LSB         = 0;
    localparam int          DECIM_W           = 13;
    localparam int          RESYNC_BIT_IN_BYTE = 0;

    // ========================================================================
    // reset values: reference on, decimation ratio 23, all else zero
    localparam logic [31:0] WORD_RESET        = 32'h4000_0017;

    // ========================================================================
    // operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL     = 3'h0,
        MODE_SELF_CAL   = 3'h1,
        MODE_SYS_OFS    = 3'h2,
        MODE_SYS_FS     = 3'h3,
        MODE_PSEUDO_CAL = 3'h4,
        MODE_BACKGROUND = 3'h5,
        MODE_SLEEP      = 3'h6,
        MODE_RESERVED   = 3'h7
    } op_mode_e;

    // ========================================================================
    // result handling and channel settling
    localparam int          RESULT_W          = 24;
    localparam logic [1:0]  CHAN_SKIP_COUNT   = 2'h3;

endpackage

//--- test/converter_control_word_assertions.sv
// assertion checker watching the control word block ports
`timescale 1ns/1ps
`default_nettype none
module converter_control_word_checker
    import ctrl_word_pkg::*;
#(
    parameter int RES_W = RESULT_W
) (
    // clock, reset and pin enables
    input wire logic               clk_i,
    input wire logic               resetn_i,
    input wire logic               sdio_oe_o,
    input wire logic               dedicated_serial_out_oe_o,
    // result path
    input wire logic               raw_result_valid_i,
    input wire logic [RES_W-1:0]   raw_result_i,
    input wire logic [RES_W-1:0]   result_register_o,
    input wire logic               result_trusted_o,
    // control fields
    input wire logic               mode_done_i,
    input wire logic [2:0]         op_mode_field_o,
    input wire logic [1:0]         channel_select_field_o,
    input wire logic               bias_enable_o,
    input wire logic               internal_ref_enable_o,
    input wire logic [DECIM_W-1:0] decimation_field_o,
    input wire logic               conversion_resync_o
);
    import ctrl_word_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ========================================================================
    // port relations
    chk_pins_exclusive: assert property (!(sdio_oe_o && dedicated_serial_out_oe_o))
        else $error("both serial outputs enabled");
    chk_reset_fields: assert property ($rose(resetn_i) |-> internal_ref_enable_o && !bias_enable_o
        && decimation_field_o == 13'h0017 && op_mode_field_o == 3'h0)
        else $error("control fields not at reset values");
    chk_resync_once: assert property (conversion_resync_o |=> !conversion_resync_o)
        else $error("resync strobe held");
    chk_result_hold: assert property (!raw_result_valid_i |=> $stable(result_register_o))
        else $error("result changed without a conversion");
    chk_result_bits: assert property (raw_result_valid_i |=>
        result_register_o[RES_W-2:0] == $past(raw_result_i[RES_W-2:0]) || result_register_o[RES_W-2:0] == '0)
        else $error("result low bits altered");
    chk_mode_revert: assert property (mode_done_i && !(op_mode_field_o inside {3'h0, 3'h5, 3'h6})
        |=> op_mode_field_o == 3'h0)
        else $error("temporary mode not reverted");
    chk_mode_keep: assert property (mode_done_i && op_mode_field_o inside {3'h0, 3'h5, 3'h6}
        |=> $stable(op_mode_field_o))
        else $error("permanent mode changed");
    chk_chan_untrusted: assert property ($changed(channel_select_field_o) |-> ##2 !result_trusted_o)
        else $error("result trusted right after channel change");
endmodule
bind converter_control_word converter_control_word_checker #(.RES_W(RES_W)) converter_control_word_checker_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .sdio_oe_o(sdio_oe_o),
    .dedicated_serial_out_oe_o(dedicated_serial_out_oe_o), .raw_result_valid_i(raw_result_valid_i),
    .raw_result_i(raw_result_i), .result_register_o(result_register_o), .result_trusted_o(result_trusted_o),
    .mode_done_i(mode_done_i), .op_mode_field_o(op_mode_field_o), .channel_select_field_o(channel_select_field_o),
    .bias_enable_o(bias_enable_o), .internal_ref_enable_o(internal_ref_enable_o),
    .decimation_field_o(decimation_field_o), .conversion_resync_o(conversion_resync_o));
`default_nettype wire

//--- test/host_link_model.sv
// host side of the serial link: frames transfers, shift clock also pulses outside them for reset sync and frame open and close
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // link towards the block
    output logic       sclk_o,
    output logic       xfer_active_o,
    output logic       xfer_read_o,
    output logic [1:0] xfer_start_idx_o,
    output logic       sdio_o,
    // pins driven by the block
    input wire logic   sdio_i,
    input wire logic   sdio_oe_i,
    input wire logic   ded_i,
    input wire logic   ded_oe_i,
    input wire logic   use_ded_i
);
    logic host_d = 1'b0;
    logic host_oe = 1'b0;
    // released line shows the inverse of the last host bit, so a stale value never passes
    assign sdio_o = host_oe ? host_d : (sdio_oe_i ? sdio_i : ~host_d);
    // idle link: clock parked high, no frame
    initial begin
        sclk_o = 1'b1;
        xfer_active_o = 1'b0;
        xfer_read_o = 1'b0;
        xfer_start_idx_o = 2'h0;
    end
    // idle shift clock pulses: reset sync, frame open and close
    task automatic pulses(input int n);
        repeat (n) begin
            #6 sclk_o = 1'b0;
            #6 sclk_o = 1'b1;
        end
    endtask
    // one data phase after two idle pulses; read bits taken at the next rising edge
    task automatic xfer(input logic rd, input logic [1:0] i, input int n, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic oe_ok);
        int k;
        rdat = 32'h0;
        oe_ok = 1'b1;
        xfer_read_o = rd;
        xfer_start_idx_o = i;
        pulses(2);
        #1 xfer_active_o = 1'b1;
        host_oe = !rd;
        for (k = 0; k < 8 * n; k++) begin
            host_d = wd[31-k];
            #6 sclk_o = 1'b0;
            #6 sclk_o = 1'b1;
            rdat = {rdat[30:0], use_ded_i ? ded_i : sdio_i};
            oe_ok = oe_ok & (use_ded_i ? ded_oe_i : sdio_oe_i);
            #1;
        end
        xfer_active_o = 1'b0;
        host_oe = 1'b0;
        pulses(2);
    endtask
endmodule
`default_nettype wire

//--- test/converter_control_word_tb.sv
// self-checking bench for the converter control word block
`timescale 1ns/1ps
`default_nettype none
module converter_control_word_tb;
    import ctrl_word_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, ready_n = 1'b1, mode_done = 1'b0, raw_valid = 1'b0, use_ded = 1'b0;
    logic [23:0] raw = 24'h0;
    logic        sclk, act, rdsel, sdio, d_sdio, d_sdio_oe, ded, ded_oe, bias, ref_en, resync, trusted;
    logic [1:0]  idx, chan;
    logic [2:0]  mode, gain, turbo;
    logic [12:0] decim;
    logic [23:0] result;
    logic [31:0] sh;
    int          bad_count = 0, cmp_count = 0, seen = 0;
    converter_control_word converter_control_word_inst (
        .clk_i(clk), .resetn_i(resetn), .sclk_i(sclk), .xfer_active_i(act), .xfer_read_i(rdsel),
        .xfer_start_idx_i(idx), .sdio_i(sdio), .sdio_o(d_sdio), .sdio_oe_o(d_sdio_oe),
        .dedicated_serial_out_o(ded), .dedicated_serial_out_oe_o(ded_oe), .result_ready_n_i(ready_n),
        .mode_done_i(mode_done), .raw_result_valid_i(raw_valid), .raw_result_i(raw), .bias_enable_o(bias),
        .internal_ref_enable_o(ref_en), .op_mode_field_o(mode), .gain_field_o(gain),
        .channel_select_field_o(chan), .turbo_rate_field_o(turbo), .decimation_field_o(decim),
        .conversion_resync_o(resync), .result_register_o(result), .result_trusted_o(trusted));
    host_link_model host_link_model_inst (
        .sclk_o(sclk), .xfer_active_o(act), .xfer_read_o(rdsel), .xfer_start_idx_o(idx), .sdio_o(sdio),
        .sdio_i(d_sdio), .sdio_oe_i(d_sdio_oe), .ded_i(ded), .ded_oe_i(ded_oe), .use_ded_i(use_ded));
    // 40 MHz system clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // count resync strobes seen at the port
    always @(posedge clk) begin
        if (resync === 1'b1) seen++;
    end
    // ========================================================================
    // expectations
    function automatic logic [31:0] stream(input logic [31:0] w, input logic [1:0] i, input int n);
        logic [31:0] s;
        logic [7:0]  b;
        int          k;
        s = 32'h0;
        for (k = 0; k < n; k++) begin
            b = w[8*(3-i) +: 8];
            if (w[BIT_ORDER_BIT]) b = {<<{b}};
            s = {s[23:0], b};
            i = w[BYTE_ORDER_BIT] ? i - 2'h1 : i + 2'h1;
        end
        return s;
    endfunction
    function automatic logic [23:0] shape(input logic [23:0] r, input logic fmt, input logic uni);
        logic [23:0] e;
        e = (uni && r[23]) ? 24'h0 : r;
        e[23] = e[23] ^ fmt;
        return e;
    endfunction
    // ========================================================================
    // drivers and comparison
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] i, input int n, input logic [31:0] d);
        int          k;
        logic [31:0] unused;
        logic        ok;
        host_link_model_inst.xfer(1'b0, i, n, d, unused, ok);
        for (k = 0; k < n; k++) sh[8*(3-(i+k)%4) +: 8] = d[31-8*k -: 8];
        sh[READY_BIT] = 1'b0;
        repeat (8) @(posedge clk);
        #2;
    endtask
    task automatic rd(input logic [1:0] i, input int n);
        logic [31:0] w, got;
        logic        ok;
        w = sh;
        w[READY_BIT] = ready_n;
        use_ded = sh[PIN_SEL_BIT];
        host_link_model_inst.xfer(1'b1, i, n, 32'h0, got, ok);
        cmp_val(got, stream(w, i, n));
        cmp_val(ok, 1'b1);
    endtask
    task automatic conv(input logic [23:0] r, input logic fmt, input logic uni);
        raw = r;
        raw_valid = 1'b1;
        @(posedge clk);
        #2 raw_valid = 1'b0;
        @(posedge clk);
        #2;
        cmp_val(result, shape(r, fmt, uni));
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #200_000;
        bad_count++;
        wrap_up();
    end
    // ========================================================================
    // main sequence
    initial begin
        logic [31:0] w;
        int          g, c, m, k;
        void'($urandom(32'h2c76));
        host_link_model_inst.pulses(4);
        repeat (5) @(posedge clk);
        #2 resetn = 1'b1;
        host_link_model_inst.pulses(3);
        sh = WORD_RESET;
        cmp_val({bias, ref_en, mode, gain, chan, turbo, decim}, {sh[31:30], sh[23:0]});
        rd(2'h0, 4);
        wr(2'h0, 1, 32'h4200_0000);
        rd(2'h0, 4);
        // random words; bias checked while later bytes still shift in
        for (k = 0; k < 8; k++) begin
            g = $urandom % 5;
            w = $urandom;
            w[31] = ~bias;
            w[23:21] = 3'h0;
            w[20:18] = g[2:0];
            w[15:13] = 3'($urandom % (5 - g));
            w[12:0] = 13'(19 + $urandom % 7982);
            c = seen;
            ready_n = 1'($urandom);
            fork
                wr(2'h0, 4, w);
                #300 cmp_val(bias, w[31]);
            join
            cmp_val(32'(seen - c), w[24]);
            cmp_val({bias, ref_en, mode, gain, chan, turbo, decim}, {sh[31:30], sh[23:0]});
            rd(2'($urandom), 1 + $urandom % 4);
        end
        // every mode, then a completion pulse
        for (m = 0; m < 8; m++) begin
            wr(2'h1, 1, {m[2:0], sh[20:16], 24'h0});
            #0 mode_done = 1'b1;
            @(posedge clk);
            #2 mode_done = 1'b0;
            @(posedge clk);
            #2;
            if (m inside {[1:4], 7}) sh[23:21] = 3'h0;
            cmp_val(mode, sh[23:21]);
        end
        // every format and clamp setting, clamp cleared before a negative value
        for (c = 0; c < 4; c++) begin
            wr(2'h0, 1, {sh[31:30], c[1:0], sh[27:25], 1'b0, 24'h0});
            conv(24'h80_0000, c[1], c[0]);
            conv(24'h7F_FFFF, c[1], c[0]);
            conv(24'h00_0000, c[1], c[0]);
            conv(24'($urandom), c[1], c[0]);
        end
        // channel change: three untrusted ready edges, then trusted
        wr(2'h1, 1, {3'h0, sh[20:18], chan + 2'h1, 24'h0});
        for (k = 1; k < 5; k++) begin
            ready_n = 1'b1;
            repeat (4) @(posedge clk);
            #2 ready_n = 1'b0;
            repeat (4) @(posedge clk);
            #2;
            cmp_val(trusted, k == 4);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
